/* rtl/mpio_defs.vh */
// Purpose: constants for the multi-use pin i/o control block
// Assumes: axi4-lite register access, 32-bit words
// Notes: offsets are byte addresses
`ifndef MPIO_DEFS_VH
`define MPIO_DEFS_VH
`define MPIO_NPIN 52
`define MPIO_NRES 16
`define MPIO_DIR_SFR_LIM 24
`define MPIO_DAT_SFR_LIM 40
`define MPIO_SEG_FIRST 24
`define MPIO_SEG_LAST 51
`define MPIO_SEG_DIR_BIT 3
`define MPIO_SEG_DAT_BIT 0
`define MPIO_PIN_PULSE_A 6
`define MPIO_PIN_PULSE_R 7
`define MPIO_PIN_MEM_CK 4
`define MPIO_PIN_MEM_DA 5
`define MPIO_PIN_OPTICAL_TRANSMIT_PIN 1
`define MPIO_PIN_OPTICAL_RECEIVE_PIN 2
// resource selector codes
`define MPIO_RES_NONE 3'h0
`define MPIO_RES_CNT0 3'h2
`define MPIO_RES_CNT1 3'h3
`define MPIO_RES_HI_RISE 3'h4
`define MPIO_RES_LO_RISE 3'h5
`define MPIO_RES_HI_FALL 3'h6
`define MPIO_RES_LO_FALL 3'h7
// register byte offsets
`define MPIO_OFS_FSEL_LO 12'h000
`define MPIO_OFS_FSEL_HI 12'h004
`define MPIO_OFS_DIR 12'h008
`define MPIO_OFS_DATA 12'h00C
`define MPIO_OFS_DATA_HI 12'h010
`define MPIO_OFS_CTRL 12'h014
`define MPIO_OFS_RSEL0 12'h018
`define MPIO_OFS_RSEL1 12'h01C
`define MPIO_OFS_IRQ_STAT 12'h020
`define MPIO_OFS_IRQ_MASK 12'h024
`define MPIO_OFS_SEG_BASE 12'h100
`define MPIO_OFS_SEG_END 12'h16C
// control register fields
`define MPIO_CTRL_PW_A 0
`define MPIO_CTRL_PW_R 1
`define MPIO_CTRL_MEM 2
`define MPIO_CTRL_OPT 3
// irq status bits
`define MPIO_IRQ_HI 0
`define MPIO_IRQ_LO 1
`define MPIO_RESP_OK 2'b00
`define MPIO_RESP_SLVERR 2'b10
`endif

/* rtl/mpio_sync.v */
// Purpose: two-stage synchroniser for a vector of pin levels
// Assumes: inputs asynchronous to clk
// Notes: first stage read only by the second
`timescale 1ns/1ps
module mpio_sync #(
  parameter W = 1
) (
  input wire clk, // system clock
  input wire nrst, // synchronous reset, active low
  input wire [W-1:0] async_in, // raw pin levels
  output wire [W-1:0] sync_out // synchronised levels
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] stab_ff;
  always @(posedge clk) begin
    if (!nrst) begin
      meta_ff <= {W{1'b0}};
      stab_ff <= {W{1'b0}};
    end else begin
      meta_ff <= async_in;
      stab_ff <= meta_ff;
    end
  end
  assign sync_out = stab_ff;
endmodule // mpio_sync

/* rtl/mpio_top.v */
// Purpose: multi-use pin i/o control with lcd sharing and resource routing
// Assumes: 100 MHz clk, axi4-lite register bus, pin index 0 is the push-button
// Notes: pin n of the vectors is general_io_pin n; pins 0..51
// Function
// - after reset every pin is an input until direction, or the optical or memory takeover in ctrl, is programmed
// - function select one gives pin to lcd, zero makes it i/o
// - in i/o function, direction bit zero input, one output, per pin
// - data register write drives outputs, read returns pin levels
// - pins 24 and up take direction from segment byte bit 3
// - pins 40 and up take data from segment byte bit 0
// - three-bit selector routes input to counters or edge interrupts
// - several pins on one resource are combined by logical or
// - pins six and seven output energy pulses when enabled and outputs
// - pins four and five can be handed to the serial memory interface
// - push-button is input only and usable as resource source
// - optical pins serve as i/o one and two when optical unused
// - pins 24 to 51 share segment byte storage for lcd and i/o
// - resource routing keeps working on output pins
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "mpio_defs.vh"
module mpio_top (
  input wire clk, // system clock 100 MHz
  input wire nrst, // synchronous reset, active low
  input wire [11:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write strobes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [11:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire [51:0] pin_in, // pin levels from pads, bit 0 push-button
  output reg [51:0] pin_out, // pin output levels
  output reg [51:0] pin_oe, // pin output enables, high while driven
  output wire [51:0] pin_lcd_sel, // high where lcd driver owns the pin
  input wire active_energy_pulse, // pulse from compute engine
  input wire reactive_energy_pulse, // pulse from compute engine
  input wire mem_clk_out, // serial memory clock from memory engine
  input wire mem_dat_out, // serial memory data from memory engine
  input wire mem_dat_oe, // serial memory data enable
  output wire mem_dat_in, // serial memory data level
  input wire optical_transmit_pin_data, // optical uart transmit data
  output wire optical_receive_pin_data, // optical uart receive level
  output wire counter0_clock, // combined counter 0 clock
  output wire counter1_clock, // combined counter 1 clock
  output wire high_priority_interrupt, // high priority edge pulse
  output wire low_priority_interrupt, // low priority edge pulse
  output wire irq // level interrupt, unmasked status set
);
  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  reg [51:0] pin_function_select_ff;
  reg [23:0] pin_direction_bits_ff;
  reg [39:0] port_data_ff;
  reg [7:0] segment_control_byte_ff [`MPIO_SEG_FIRST:`MPIO_SEG_LAST];
  reg [3:0] ctrl_ff;
  reg [2:0] pin_resource_select_ff [0:`MPIO_NRES-1];
  reg [1:0] irq_stat_ff;
  reg [1:0] irq_mask_ff;
  reg aw_hold_ff;
  reg w_hold_ff;
  reg [11:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg [51:0] lvl_prev_ff;
  wire [51:0] lvl_sync;
  wire [51:0] dir_eff;
  wire [51:0] dat_eff;
  wire wr_go;
  wire rd_go;
  wire wr_hit;
  wire [5:0] wr_seg_idx;
  wire [5:0] rd_seg_idx;
  wire pw_a_on;
  wire pw_r_on;
  wire mem_on;
  wire opt_on;
  wire [`MPIO_NRES-1:0] res_cnt0;
  wire [`MPIO_NRES-1:0] res_cnt1;
  wire [`MPIO_NRES-1:0] res_hi;
  wire [`MPIO_NRES-1:0] res_lo;
  integer i, j, k;
  genvar g;
  // -------------------------------------------------------------
  // pin input synchroniser
  // -------------------------------------------------------------
  mpio_sync #(
    .W(52)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in(pin_in),
    .sync_out(lvl_sync)
  );
  // -------------------------------------------------------------
  // effective direction and data per pin
  // -------------------------------------------------------------
  generate
    for (g = 0; g < 52; g = g + 1) begin : g_pin
      if (g == 0) begin : g_pb
        assign dir_eff[g] = 1'b0;
        assign dat_eff[g] = 1'b0;
      end else if (g < `MPIO_DIR_SFR_LIM) begin : g_lo
        assign dir_eff[g] = pin_direction_bits_ff[g];
        assign dat_eff[g] = port_data_ff[g];
      end else if (g < `MPIO_DAT_SFR_LIM) begin : g_mid
        assign dir_eff[g] = segment_control_byte_ff[g][`MPIO_SEG_DIR_BIT];
        assign dat_eff[g] = port_data_ff[g];
      end else begin : g_hi
        assign dir_eff[g] = segment_control_byte_ff[g][`MPIO_SEG_DIR_BIT];
        assign dat_eff[g] = segment_control_byte_ff[g][`MPIO_SEG_DAT_BIT];
      end
    end
  endgenerate
  assign pin_lcd_sel = pin_function_select_ff;
  assign pw_a_on = ctrl_ff[`MPIO_CTRL_PW_A];
  assign pw_r_on = ctrl_ff[`MPIO_CTRL_PW_R];
  assign mem_on = ctrl_ff[`MPIO_CTRL_MEM];
  assign opt_on = ctrl_ff[`MPIO_CTRL_OPT];
  // -------------------------------------------------------------
  // pad drive
  // -------------------------------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      pin_out <= 52'h0_0000_0000_0000;
      pin_oe <= 52'h0_0000_0000_0000;
    end else begin
      for (k = 0; k < 52; k = k + 1) begin
        pin_oe[k] <= ~pin_function_select_ff[k] & dir_eff[k];
        pin_out[k] <= dat_eff[k];
      end
      pin_oe[0] <= 1'b0;
      if (opt_on) begin
        pin_oe[`MPIO_PIN_OPTICAL_TRANSMIT_PIN] <= 1'b1;
        pin_out[`MPIO_PIN_OPTICAL_TRANSMIT_PIN] <= optical_transmit_pin_data;
        pin_oe[`MPIO_PIN_OPTICAL_RECEIVE_PIN] <= 1'b0;
      end
      if (mem_on) begin
        pin_oe[`MPIO_PIN_MEM_CK] <= 1'b1;
        pin_out[`MPIO_PIN_MEM_CK] <= mem_clk_out;
        pin_oe[`MPIO_PIN_MEM_DA] <= mem_dat_oe;
        pin_out[`MPIO_PIN_MEM_DA] <= mem_dat_out;
      end
      if (pw_a_on && !pin_function_select_ff[`MPIO_PIN_PULSE_A] && dir_eff[`MPIO_PIN_PULSE_A])
        pin_out[`MPIO_PIN_PULSE_A] <= active_energy_pulse;
      if (pw_r_on && !pin_function_select_ff[`MPIO_PIN_PULSE_R] && dir_eff[`MPIO_PIN_PULSE_R])
        pin_out[`MPIO_PIN_PULSE_R] <= reactive_energy_pulse;
    end
  end
  assign mem_dat_in = lvl_sync[`MPIO_PIN_MEM_DA];
  assign optical_receive_pin_data = lvl_sync[`MPIO_PIN_OPTICAL_RECEIVE_PIN];
  // -------------------------------------------------------------
  // resource routing, pins 0..15 carry selectors
  // -------------------------------------------------------------
  generate
    for (g = 0; g < `MPIO_NRES; g = g + 1) begin : g_res
      // levels read back from the pad even while driving, so own pulses are counted
      wire rise = lvl_sync[g] & ~lvl_prev_ff[g];
      wire fall = ~lvl_sync[g] & lvl_prev_ff[g];
      wire [2:0] sel = pin_resource_select_ff[g];
      assign res_cnt0[g] = (sel == `MPIO_RES_CNT0) & lvl_sync[g];
      assign res_cnt1[g] = (sel == `MPIO_RES_CNT1) & lvl_sync[g];
      assign res_hi[g] = ((sel == `MPIO_RES_HI_RISE) & rise) | ((sel == `MPIO_RES_HI_FALL) & fall);
      assign res_lo[g] = ((sel == `MPIO_RES_LO_RISE) & rise) | ((sel == `MPIO_RES_LO_FALL) & fall);
    end
  endgenerate
  assign counter0_clock = |res_cnt0;
  assign counter1_clock = |res_cnt1;
  assign high_priority_interrupt = |res_hi;
  assign low_priority_interrupt = |res_lo;
  assign irq = |(irq_stat_ff & irq_mask_ff);
  // -------------------------------------------------------------
  // axi4-lite write path
  // -------------------------------------------------------------
  assign s_axi_awready = ~aw_hold_ff & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_ff & ~s_axi_bvalid;
  wire aw_now = aw_hold_ff | s_axi_awvalid;
  wire w_now = w_hold_ff | s_axi_wvalid;
  wire [11:0] wa = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wd = w_hold_ff ? wdata_ff : s_axi_wdata;
  wire [3:0] ws = w_hold_ff ? wstrb_ff : s_axi_wstrb;
  assign wr_go = aw_now & w_now & ~s_axi_bvalid;
  assign wr_seg_idx = wa[7:2] + 6'd24;
  wire wr_seg = (wa >= `MPIO_OFS_SEG_BASE) && (wa <= `MPIO_OFS_SEG_END);
  assign wr_hit = wr_seg || (wa <= `MPIO_OFS_IRQ_MASK);
  always @(posedge clk) begin
    if (!nrst) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MPIO_RESP_OK;
      pin_function_select_ff <= 52'h0_0000_0000_0000;
      pin_direction_bits_ff <= 24'h00_0000;
      port_data_ff <= 40'h00_0000_0000;
      ctrl_ff <= 4'h0;
      irq_mask_ff <= 2'h0;
      for (i = 0; i < `MPIO_NRES; i = i + 1)
        pin_resource_select_ff[i] <= `MPIO_RES_NONE;
      for (i = `MPIO_SEG_FIRST; i <= `MPIO_SEG_LAST; i = i + 1)
        segment_control_byte_ff[i] <= 8'h00;
    end else begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_awvalid && s_axi_awready && !wr_go) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_go) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `MPIO_RESP_OK : `MPIO_RESP_SLVERR;
        // one byte per segment word; lcd and i/o bits share it
        if (wr_seg && ws[0])
          segment_control_byte_ff[wr_seg_idx] <= wd[7:0];
        case (wa)
          `MPIO_OFS_FSEL_LO: begin
            for (i = 0; i < 32; i = i + 1)
              if (ws[i/8]) pin_function_select_ff[i] <= wd[i];
          end
          `MPIO_OFS_FSEL_HI: begin
            for (i = 0; i < 20; i = i + 1)
              if (ws[i/8]) pin_function_select_ff[32+i] <= wd[i];
          end
          `MPIO_OFS_DIR: begin
            for (i = 0; i < 24; i = i + 1)
              if (ws[i/8]) pin_direction_bits_ff[i] <= wd[i];
          end
          `MPIO_OFS_DATA: begin
            for (i = 0; i < 32; i = i + 1)
              if (ws[i/8]) port_data_ff[i] <= wd[i];
          end
          `MPIO_OFS_DATA_HI: begin
            if (ws[0]) port_data_ff[39:32] <= wd[7:0];
          end
          `MPIO_OFS_CTRL: begin
            if (ws[0]) ctrl_ff <= wd[3:0];
          end
          `MPIO_OFS_RSEL0: begin
            for (i = 0; i < 8; i = i + 1)
              if (ws[i/2]) pin_resource_select_ff[i] <= wd[4*i +: 3];
          end
          `MPIO_OFS_RSEL1: begin
            for (i = 0; i < 8; i = i + 1)
              if (ws[i/2]) pin_resource_select_ff[8+i] <= wd[4*i +: 3];
          end
          `MPIO_OFS_IRQ_MASK: begin
            if (ws[0]) irq_mask_ff <= wd[1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end
  // -------------------------------------------------------------
  // edge history and sticky interrupt status (set wins over clear)
  // -------------------------------------------------------------
  wire stat_wr = wr_go && (wa == `MPIO_OFS_IRQ_STAT) && ws[0];
  wire [1:0] stat_clr = stat_wr ? wd[1:0] : 2'b00;
  wire [1:0] stat_set = {low_priority_interrupt, high_priority_interrupt};
  always @(posedge clk) begin
    if (!nrst) begin
      lvl_prev_ff <= 52'h0_0000_0000_0000;
      irq_stat_ff <= 2'h0;
    end else begin
      lvl_prev_ff <= lvl_sync;
      irq_stat_ff <= (irq_stat_ff & ~stat_clr) | stat_set;
    end
  end
  // -------------------------------------------------------------
  // axi4-lite read path
  // -------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_go = s_axi_arvalid & s_axi_arready;
  assign rd_seg_idx = s_axi_araddr[7:2] + 6'd24;
  wire rd_seg = (s_axi_araddr >= `MPIO_OFS_SEG_BASE) && (s_axi_araddr <= `MPIO_OFS_SEG_END);
  wire [7:0] seg_rd = segment_control_byte_ff[rd_seg_idx];
  always @(posedge clk) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MPIO_RESP_OK;
    end else begin
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `MPIO_RESP_OK;
        s_axi_rdata <= 32'h0000_0000;
        if (rd_seg)
          // bit 0 reads the pin level when the pin is in i/o function
          s_axi_rdata <= {24'h00_0000, seg_rd[7:1],
            pin_function_select_ff[rd_seg_idx] ? seg_rd[0] : lvl_sync[rd_seg_idx]};
        else begin
          case (s_axi_araddr)
            `MPIO_OFS_FSEL_LO: s_axi_rdata <= pin_function_select_ff[31:0];
            `MPIO_OFS_FSEL_HI: s_axi_rdata <= {12'h000, pin_function_select_ff[51:32]};
            `MPIO_OFS_DIR: s_axi_rdata <= {8'h00, pin_direction_bits_ff[23:1], 1'b0};
            `MPIO_OFS_DATA: s_axi_rdata <= lvl_sync[31:0];
            `MPIO_OFS_DATA_HI: s_axi_rdata <= {24'h00_0000, lvl_sync[39:32]};
            `MPIO_OFS_CTRL: s_axi_rdata <= {28'h000_0000, ctrl_ff};
            `MPIO_OFS_RSEL0: begin
              for (j = 0; j < 8; j = j + 1)
                s_axi_rdata[4*j +: 4] <= {1'b0, pin_resource_select_ff[j]};
            end
            `MPIO_OFS_RSEL1: begin
              for (j = 0; j < 8; j = j + 1)
                s_axi_rdata[4*j +: 4] <= {1'b0, pin_resource_select_ff[8+j]};
            end
            `MPIO_OFS_IRQ_STAT: s_axi_rdata <= {30'h0000_0000, irq_stat_ff};
            `MPIO_OFS_IRQ_MASK: s_axi_rdata <= {30'h0000_0000, irq_mask_ff};
            default: s_axi_rresp <= `MPIO_RESP_SLVERR;
          endcase
        end
      end
    end
  end
endmodule // mpio_top

/* tb/mpio_top_sva.sv */
// Purpose: port checker for the multi-use pin i/o block
// Assumes: one clock, synchronous active-low reset
// Notes: sees only top-level ports; bound after the module
`timescale 1ns/1ps
module mpio_chk (
  input wire clk, // system clock
  input wire nrst, // reset, active low
  input wire s_axi_awready, // write address ready
  input wire s_axi_wready, // write data ready
  input wire s_axi_bvalid, // write response valid
  input wire [51:0] pin_in, // pad levels
  input wire [51:0] pin_oe, // pad enables
  input wire [51:0] pin_lcd_sel, // lcd ownership
  input wire mem_dat_in, // memory data level
  input wire optical_receive_pin_data, // optical receive level
  input wire counter0_clock, // counter 0 clock
  input wire counter1_clock, // counter 1 clock
  input wire high_priority_interrupt, // high priority pulse
  input wire low_priority_interrupt // low priority pulse
);
  reg [2:0] cyc_ff;
  wire [2:0] nxt_cyc = (cyc_ff == 3'h7) ? cyc_ff : cyc_ff + 3'h1;
  // synchroniser history is only meaningful once it has refilled
  wire warm = (cyc_ff == 3'h7);
  wire [15:0] lo_pads = pin_in[15:0];
  always @(posedge clk) begin
    if (!nrst) begin
      cyc_ff <= 3'h0;
    end else begin
      cyc_ff <= nxt_cyc;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_reset_all_input: assert property ($rose(nrst) |-> (pin_oe == 52'h0) [*2])
    else $error("pin driven right after reset");
  a_button_input_only: assert property (pin_oe[0] == 1'h0)
    else $error("push-button pin driven");
  a_lcd_no_drive: assert property ((pin_lcd_sel[51:6] & $past(pin_lcd_sel[51:6]) & pin_oe[51:6]) == 46'h0)
    else $error("lcd pin driven as i/o");
  a_rx_pad_level: assert property (warm |-> optical_receive_pin_data == $past(pin_in[2], 2))
    else $error("optical receive level wrong");
  a_mem_pad_level: assert property (warm |-> mem_dat_in == $past(pin_in[5], 2))
    else $error("memory data level wrong");
  a_cnt0_has_src: assert property (warm && counter0_clock |-> |$past(lo_pads, 2))
    else $error("counter 0 clock high with no pad high");
  a_cnt1_has_src: assert property (warm && counter1_clock |-> |$past(lo_pads, 2))
    else $error("counter 1 clock high with no pad high");
  a_int_from_edge: assert property (
    warm && (high_priority_interrupt || low_priority_interrupt)
    |-> $past(lo_pads, 2) != $past(lo_pads, 3) || $past(lo_pads, 3) != $past(lo_pads, 4)
    || $past(lo_pads, 4) != $past(lo_pads, 5))
    else $error("interrupt pulse without pad edge");
  a_bus_busy_hold: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
endmodule // mpio_chk

bind mpio_top mpio_chk u_chk (.clk, .nrst, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .pin_in, .pin_oe, .pin_lcd_sel, .mem_dat_in, .optical_receive_pin_data, .counter0_clock,
  .counter1_clock, .high_priority_interrupt, .low_priority_interrupt);

/* tb/mpio_pad_model.sv */
// Purpose: pads with external sources and loads
// Assumes: external source drives every undriven pad
// Notes: a driven pad reads back its own drive
`timescale 1ns/1ps
module mpio_pad_model (
  input wire [51:0] pin_out, // drive level
  input wire [51:0] pin_oe, // drive enable
  input wire [51:0] ext_lvl, // external source level
  output wire [51:0] pin_in // pad level
);
  // read-back of driven pads lets output pulses be counted
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // mpio_pad_model

/* tb/test_mpio_top.sv */
// Purpose: register-level test of the multi-use pin block
// Assumes: 100 MHz clock, 12-cycle reset
// Notes: pads looped through the pad model
`timescale 1ns/1ps
`include "mpio_defs.vh"
module test_mpio_top;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [11:0] s_axi_awaddr = 12'h000;
  reg [11:0] s_axi_araddr = 12'h000;
  reg [31:0] s_axi_wdata = 32'h0000_0000;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg active_energy_pulse = 1'b0, reactive_energy_pulse = 1'b0, optical_transmit_pin_data = 1'b0;
  reg mem_clk_out = 1'b0, mem_dat_out = 1'b0, mem_dat_oe = 1'b0;
  reg [51:0] ext = 52'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [51:0] pin_in, pin_out, pin_oe, pin_lcd_sel;
  wire mem_dat_in, optical_receive_pin_data, counter0_clock, counter1_clock, irq;
  wire high_priority_interrupt, low_priority_interrupt;
  integer error_cnt = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer i;
  reg [31:0] rd;
  reg [1:0] rsp;
  reg [3:0] seen;
  always #5 clk = ~clk;
  mpio_top DUT (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .pin_lcd_sel,
    .active_energy_pulse, .reactive_energy_pulse, .mem_clk_out, .mem_dat_out, .mem_dat_oe,
    .mem_dat_in, .optical_transmit_pin_data, .optical_receive_pin_data, .counter0_clock, .counter1_clock,
    .high_priority_interrupt, .low_priority_interrupt, .irq);
  mpio_pad_model u_pad (.pin_out, .pin_oe, .ext_lvl(ext), .pin_in);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input [63:0] sv, input [63:0] ev, input string what);
    check_count = check_count + 1;
    if (sv !== ev) begin
      error_cnt = error_cnt + 1;
      $display("Error %0s expected %h seen %h", what, ev, sv);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input [11:0] a, input [31:0] d, input [1:0] er);
    reg ad, wd;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er, "bresp");
  endtask
  task rdr(input [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task rdc(input [11:0] a, input [31:0] e);
    rdr(a);
    chk({rsp, rd}, {2'h0, e}, "rdata");
  endtask
  // raise then drop one pad, collecting {cnt0, cnt1, hi, lo} after the rise and only {hi, lo} after the drop
  task hit(input integer p, input [3:0] er, input [1:0] ef);
    @(posedge clk);
    ext[p] <= 1'b1;
    seen = 4'h0;
    repeat (6) begin
      @(posedge clk);
      seen = seen | {counter0_clock, counter1_clock, high_priority_interrupt, low_priority_interrupt};
    end
    chk(seen, er, "rise route");
    ext[p] <= 1'b0;
    seen = 4'h0;
    repeat (6) begin
      @(posedge clk);
      seen = seen | {2'h0, high_priority_interrupt, low_priority_interrupt};
    end
    chk(seen, {2'h0, ef}, "fall route");
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    tick(3);
    chk(pin_oe, 52'h0, "oe after reset");
    rdc(`MPIO_OFS_DIR, 32'h0000_0000);
    $display("test reset done");
    wr(`MPIO_OFS_DIR, 32'h00FF_0000, 2'h0);
    wr(`MPIO_OFS_DATA, 32'h005A_0000, 2'h0);
    tick(2);
    chk({pin_oe[23:16], pin_out[23:16]}, 16'hFF5A, "drive");
    chk(pin_oe[15:0], 16'h0, "inputs");
    tick(2);
    rdc(`MPIO_OFS_DATA, 32'h005A_0000);
    wr(`MPIO_OFS_FSEL_LO, 32'h0080_0000, 2'h0);
    tick(2);
    chk({pin_lcd_sel[23], pin_oe[23]}, 2'h2, "lcd owns");
    wr(`MPIO_OFS_FSEL_LO, 32'h0000_0000, 2'h0);
    tick(2);
    chk(pin_oe[23], 1'h1, "i/o again");
    wr(12'h200, 32'hFFFF_FFFF, 2'h2);
    rdr(12'h200);
    chk({rsp, rd}, {2'h2, 32'h0}, "unmapped");
    $display("test dir data done");
    wr(12'h118, 32'h0000_0008, 2'h0);
    wr(`MPIO_OFS_DATA, 32'h405A_0000, 2'h0);
    tick(2);
    chk({pin_oe[30], pin_out[30]}, 2'h3, "seg dir");
    wr(12'h154, 32'h0000_0009, 2'h0);
    tick(4);
    chk({pin_oe[45], pin_out[45]}, 2'h3, "seg data");
    rdc(12'h154, 32'h0000_0009);
    rdr(12'h154);
    wr(12'h154, rd & 32'hFFFF_FFFE, 2'h0);
    tick(2);
    chk({pin_oe[45], pin_out[45]}, 2'h2, "seg rmw");
    $display("test segment done");
    wr(`MPIO_OFS_RSEL0, 32'h0000_0002, 2'h0);
    wr(`MPIO_OFS_RSEL1, 32'h7654_3221, 2'h0);
    hit(0, 4'h8, 2'h0);
    for (i = 8; i < 16; i = i + 1) begin
      hit(i, 32'h0012_4880 >> (4 * (i - 8)), 16'h6000 >> (2 * (i - 8)));
    end
    ext[9] <= 1'b1;
    ext[10] <= 1'b1;
    tick(4);
    ext[9] <= 1'b0;
    tick(4);
    chk(counter0_clock, 1'h1, "or held");
    ext[10] <= 1'b0;
    tick(4);
    chk(counter0_clock, 1'h0, "or dropped");
    rdc(`MPIO_OFS_IRQ_STAT, 32'h0000_0003);
    chk(irq, 1'h0, "irq masked");
    wr(`MPIO_OFS_IRQ_MASK, 32'h0000_0003, 2'h0);
    tick(2);
    chk(irq, 1'h1, "irq on");
    wr(`MPIO_OFS_IRQ_STAT, 32'h0000_0003, 2'h0);
    tick(2);
    chk(irq, 1'h0, "irq cleared");
    wr(`MPIO_OFS_DIR, 32'h0000_1000, 2'h0);
    seen = 4'h0;
    wr(`MPIO_OFS_DATA, 32'h0000_1000, 2'h0);
    repeat (8) begin
      @(posedge clk);
      seen = seen | {3'h0, high_priority_interrupt};
    end
    chk(seen, 4'h1, "output pin edge");
    $display("test resources done");
    wr(`MPIO_OFS_DIR, 32'h0000_00C0, 2'h0);
    wr(`MPIO_OFS_CTRL, 32'h0000_0003, 2'h0);
    active_energy_pulse <= 1'b1;
    tick(2);
    chk({pin_oe[7:6], pin_out[7:6]}, 4'hD, "active pulse");
    active_energy_pulse <= 1'b0;
    reactive_energy_pulse <= 1'b1;
    tick(2);
    chk(pin_out[7:6], 2'h2, "reactive pulse");
    wr(`MPIO_OFS_CTRL, 32'h0000_0004, 2'h0);
    tick(2);
    chk(pin_out[7], 1'h0, "pulse released");
    mem_clk_out <= 1'b1;
    mem_dat_out <= 1'b1;
    mem_dat_oe <= 1'b1;
    tick(3);
    chk({pin_out[5:4], pin_oe[5:4]}, 4'hF, "memory pins");
    wr(`MPIO_OFS_CTRL, 32'h0000_0008, 2'h0);
    optical_transmit_pin_data <= 1'b1;
    ext[2] <= 1'b1;
    tick(3);
    chk({pin_out[1], pin_oe[1], optical_receive_pin_data}, 3'h7, "optical");
    optical_transmit_pin_data <= 1'b0;
    wr(`MPIO_OFS_CTRL, 32'h0000_0000, 2'h0);
    wr(`MPIO_OFS_DIR, 32'h0000_0002, 2'h0);
    wr(`MPIO_OFS_DATA, 32'h0000_0002, 2'h0);
    tick(2);
    chk({pin_out[1], pin_oe[1]}, 2'h3, "optical as i/o");
    $display("test takeover done");
    // reset again while pins 1, 30 and 45 are driven
    nrst <= 1'b0;
    tick(3);
    nrst <= 1'b1;
    tick(3);
    chk(pin_oe, 52'h0, "oe after second reset");
    rdc(`MPIO_OFS_DIR, 32'h0000_0000);
    rdc(12'h118, 32'h0000_0000);
    $display("test second reset done");
    report_and_stop;
  end
endmodule // test_mpio_top
